// *** bte_cto_timer.sv ***
/*
 * Completion timeout tracker: one counter per non-posted request tag.
 * Assumes issue and completion strobes are synchronous to core_clk and
 * that a tag is reused only after its completion or its timeout.
 */
`timescale 1ns/10ps
`include "bte_err_map.svh"

module bte_cto_timer #(
	parameter int unsigned CTO_CYCLES = `BTE_CTO_CYCLES
) (
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic issue,
	input wire logic [`BTE_TAG_W-1:0] issue_tag,
	input wire logic cpl,
	input wire logic [`BTE_TAG_W-1:0] cpl_tag,
	output logic expire_reg,
	output logic [`BTE_TAG_W-1:0] expire_tag_reg,
	output logic [`BTE_TAGS-1:0] busy
);
	import bte_pkg::*;

	localparam logic [`BTE_CNT_W-1:0] LIM = `BTE_CNT_W'(CTO_CYCLES - 1);

	logic [`BTE_TAGS-1:0] hit;
	logic [`BTE_TAGS-1:0] grant;
	logic [`BTE_TAG_W-1:0] grant_tag;

	// Only one timeout leaves per cycle; the others hold at the limit.
	assign grant = hit & (~hit + `BTE_TAGS'(1));

	always_comb begin
		grant_tag = '0;
		for (int i = `BTE_TAGS - 1; i >= 0; i--) begin
			if (grant[i]) begin
				grant_tag = `BTE_TAG_W'(i);
			end
		end
	end

	genvar g;
	generate
		for (g = 0; g < `BTE_TAGS; g++) begin : g_slot
			bte_slot_t state_reg;
			bte_slot_t state_next;
			logic [`BTE_CNT_W-1:0] cnt_reg;
			logic [`BTE_CNT_W-1:0] cnt_next;
			wire start = issue && (issue_tag == `BTE_TAG_W'(g));
			wire done = cpl && (cpl_tag == `BTE_TAG_W'(g));

			// A completion in the expiry cycle still wins the race.
			assign hit[g] = (state_reg == SLOT_WAIT) && (cnt_reg == LIM) && !done;
			assign busy[g] = state_reg;

			always_comb begin
				state_next = state_reg;
				cnt_next = cnt_reg;
				unique case (state_reg)
					SLOT_IDLE: if (start) begin
						state_next = SLOT_WAIT;
						cnt_next = '0;
					end
					SLOT_WAIT: if (done || grant[g]) begin
						state_next = SLOT_IDLE;
					end else if (!hit[g]) begin
						cnt_next = cnt_reg + `BTE_CNT_W'(1);
					end
				endcase
			end

			always_ff @(posedge core_clk or negedge rst_b) begin
				if (!rst_b) begin
					state_reg <= SLOT_IDLE;
					cnt_reg <= '0;
				end else begin
					state_reg <= state_next;
					cnt_reg <= cnt_next;
				end
			end
		end
	endgenerate

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			expire_reg <= 1'b0;
			expire_tag_reg <= '0;
		end else begin
			expire_reg <= |hit;
			expire_tag_reg <= grant_tag;
		end
	end

endmodule

// *** bte_err_map.svh ***
/*
 * Constants of the bridge error-reporting block: timing, tag space and
 * first-error pointer codes.
 * Assumes it is included by bare name into each design file that needs it.
 */
`ifndef BTE_ERR_MAP_SVH
`define BTE_ERR_MAP_SVH

// ********************************
// Timing
// ********************************
`define BTE_CLK_PERIOD_NS 8
`define BTE_CTO_TIME_US 50
// Least time, so the cycle count rounds up.
`define BTE_CTO_CYCLES (((`BTE_CTO_TIME_US * 1000) + `BTE_CLK_PERIOD_NS - 1) / `BTE_CLK_PERIOD_NS)

// ********************************
// Tracked request tags
// ********************************
`define BTE_TAG_W 2
`define BTE_TAGS 4
`define BTE_CNT_W 16

// ********************************
// First-error pointer
// ********************************
`define BTE_PTR_W 5
`define BTE_PTR_RST 5'h00
`define BTE_PTR_SEC_SERR 5'h07

`endif

// *** bte_far_end.sv ***
/* Far side: upstream completer and a secondary target.
   Assumes the bench chooses when completions are lost. */
`timescale 1ns/10ps
`include "bte_err_map.svh"
module bte_far_end (
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic lose_cpl,
	input wire logic flag_parity,
	input wire logic poison_write_fwd,
	input wire logic np_issue,
	input wire logic [`BTE_TAG_W-1:0] np_issue_tag,
	output logic cpl_rcvd,
	output logic [`BTE_TAG_W-1:0] cpl_rcvd_tag,
	output logic secondary_parity_error_pin_b
);
	logic [1:0] wait_reg;
	// The parity pin has a pull-up, so it is high whenever the target is silent.
	assign secondary_parity_error_pin_b = !(poison_write_fwd && flag_parity);
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			wait_reg <= 2'h0;
			cpl_rcvd <= 1'b0;
			cpl_rcvd_tag <= 2'h0;
		end else begin
			cpl_rcvd <= (wait_reg == 2'h1);
			if (np_issue && !lose_cpl) begin
				wait_reg <= 2'h3;
				cpl_rcvd_tag <= np_issue_tag;
			end else if (wait_reg != 2'h0) begin
				wait_reg <= wait_reg - 2'h1;
			end else if (cpl_rcvd) begin
				// A stale tag must not look valid once the pulse is gone.
				cpl_rcvd_tag <= ~cpl_rcvd_tag;
			end
		end
	end
endmodule

// *** bte_pkg.sv ***
/*
 * Types of the bridge error-reporting block.
 * Assumes nothing of its surroundings.
 */
package bte_pkg;

	// ********************************
	// Configuration bits from software
	// ********************************
	typedef struct packed {
		logic system_error_enable;
		logic fatal_report_enable;
		logic nonfatal_report_enable;
		logic parity_error_response_enable;
		logic secondary_parity_response_enable;
		logic discard_timeout_serr_enable;
		logic bridge_serr_forward_enable;
		logic cto_mask;
		logic cto_severity;
		logic dtd_mask;
		logic dtd_severity;
		logic sec_serr_mask;
		logic sec_serr_severity;
		logic ecrc_mask;
		logic ecrc_severity;
		logic poison_mask;
		logic poison_severity;
	} bte_cfg_t;

	// ********************************
	// One-cycle event strobes
	// ********************************
	typedef struct packed {
		logic discard_timeout;
		logic sec_serr_seen;
		logic ecrc_fail;
		logic poison_rx;
		logic poison_is_read_cpl;
		logic poison_advisory;
		logic poison_write_fwd;
	} bte_evt_t;

	// ********************************
	// Sticky status bits
	// ********************************
	typedef struct packed {
		logic completion_timeout_status;
		logic discard_timer_timeout_status;
		logic signaled_system_error;
		logic sec_received_system_error;
		logic secondary_serr_asserted_status;
		logic detected_parity_error;
		logic fatal_error_detected;
		logic nonfatal_error_detected;
		logic correctable_error_detected;
		logic advisory_nonfatal_status;
		logic poisoned_packet_status;
		logic ecrc_status;
		logic master_data_parity_error;
		logic secondary_parity_asserted_status;
		logic sec_master_data_parity_error;
	} bte_stat_t;

	typedef struct packed {
		logic fatal;
		logic nonfatal;
	} bte_msg_t;

	typedef enum logic [0:0] {
		SLOT_IDLE = 1'b0,
		SLOT_WAIT = 1'b1
	} bte_slot_t;

endpackage

// *** bte_report.sv ***
/*
 * Error-reporting core of the bridge: turns timeouts, secondary system
 * errors, ECRC failures and poisoned packets into sticky status and
 * upstream fatal or non-fatal message requests.
 * Assumes all inputs are synchronous to core_clk, event inputs are
 * one-cycle strobes, and software clears status with one-cycle pulses.
 */
`timescale 1ns/10ps
`include "bte_err_map.svh"

module bte_report #(
	parameter int unsigned CTO_CYCLES = `BTE_CTO_CYCLES
) (
	input wire logic core_clk,
	input wire logic rst_b,
	input bte_pkg::bte_cfg_t cfg,
	input bte_pkg::bte_evt_t evt,
	input wire logic np_issue,
	input wire logic [`BTE_TAG_W-1:0] np_issue_tag,
	input wire logic cpl_rcvd,
	input wire logic [`BTE_TAG_W-1:0] cpl_rcvd_tag,
	input wire logic secondary_parity_error_pin_b,
	input bte_pkg::bte_stat_t status_clear,
	input wire logic first_error_pointer_clear,
	output bte_pkg::bte_stat_t status_reg,
	output logic [`BTE_PTR_W-1:0] secondary_first_error_pointer_reg,
	output bte_pkg::bte_msg_t err_msg_reg,
	output logic ur_abort_reg,
	output logic [`BTE_TAG_W-1:0] ur_abort_tag_reg,
	output logic tlp_discard_reg,
	output logic [`BTE_TAGS-1:0] tag_busy_reg
);
	import bte_pkg::*;

	// ********************************
	// Local decoding
	// ********************************

	// Reporting is allowed when the source is not masked and either the
	// system-error enable or the report enable matching the severity is on.
	function automatic logic report_ok(
		input logic unmasked,
		input logic sev,
		input bte_cfg_t c
	);
		logic en;
		en = sev ? c.fatal_report_enable : c.nonfatal_report_enable;
		return unmasked && (c.system_error_enable || en);
	endfunction

	// ********************************
	// Completion timeout tracking
	// ********************************
	logic cto_evt;
	logic [`BTE_TAG_W-1:0] cto_tag;
	logic [`BTE_TAGS-1:0] busy;

	bte_cto_timer #(
		.CTO_CYCLES(CTO_CYCLES)
	) u_cto_timer (
		.core_clk(core_clk),
		.rst_b(rst_b),
		.issue(np_issue),
		.issue_tag(np_issue_tag),
		.cpl(cpl_rcvd),
		.cpl_tag(cpl_rcvd_tag),
		.expire_reg(cto_evt),
		.expire_tag_reg(cto_tag),
		.busy(busy)
	);

	// ********************************
	// Message decisions per source
	// ********************************
	wire cto_unmasked = !cfg.cto_mask;
	wire cto_send = cto_evt && report_ok(cto_unmasked, cfg.cto_severity, cfg);

	// The discard_timeout_serr_enable bit overrides the mask for discard timeouts.
	wire dtd_unmasked = !cfg.dtd_mask || cfg.discard_timeout_serr_enable;
	wire dtd_send = evt.discard_timeout && report_ok(dtd_unmasked, cfg.dtd_severity, cfg);

	wire serr_unmasked = !cfg.sec_serr_mask || cfg.bridge_serr_forward_enable;
	wire serr_send = evt.sec_serr_seen && report_ok(serr_unmasked, cfg.sec_serr_severity, cfg);

	wire ecrc_unmasked = !cfg.ecrc_mask;
	wire ecrc_send = evt.ecrc_fail && report_ok(ecrc_unmasked, cfg.ecrc_severity, cfg);

	// An advisory poisoned packet is logged as correctable and sends no
	// uncorrectable message.
	wire poison_unc = evt.poison_rx && !evt.poison_advisory;
	wire poison_adv = evt.poison_rx && evt.poison_advisory;
	wire poison_unmasked = !cfg.poison_mask;
	wire poison_send = poison_unc && report_ok(poison_unmasked, cfg.poison_severity, cfg);

	// ********************************
	// Message merge
	// ********************************
	wire fatal_send =
		(cto_send && cfg.cto_severity) ||
		(dtd_send && cfg.dtd_severity) ||
		(serr_send && cfg.sec_serr_severity) ||
		(ecrc_send && cfg.ecrc_severity) ||
		(poison_send && cfg.poison_severity);

	wire nonfatal_send =
		(cto_send && !cfg.cto_severity) ||
		(dtd_send && !cfg.dtd_severity) ||
		(serr_send && !cfg.sec_serr_severity) ||
		(ecrc_send && !cfg.ecrc_severity) ||
		(poison_send && !cfg.poison_severity);

	// A poisoned packet only counts toward signaled system error when its
	// message is fatal; a non-fatal one leaves the bit alone.
	wire sse_from_poison = poison_send && cfg.poison_severity;
	wire sse_from_other = cto_send || dtd_send || serr_send || ecrc_send;
	wire sse_set = cfg.system_error_enable && (sse_from_other || sse_from_poison);

	// ********************************
	// Detected-severity bits
	// ********************************
	// Detection is recorded whatever the mask says.
	wire fatal_det =
		(cto_evt && cfg.cto_severity) ||
		(evt.discard_timeout && cfg.dtd_severity) ||
		(evt.sec_serr_seen && cfg.sec_serr_severity) ||
		(evt.ecrc_fail && cfg.ecrc_severity) ||
		(poison_unc && cfg.poison_severity);

	wire nonfatal_det =
		(cto_evt && !cfg.cto_severity) ||
		(evt.discard_timeout && !cfg.dtd_severity) ||
		(evt.sec_serr_seen && !cfg.sec_serr_severity) ||
		(evt.ecrc_fail && !cfg.ecrc_severity) ||
		(poison_unc && !cfg.poison_severity);

	// ********************************
	// Parity related sets
	// ********************************
	wire dpe_set = evt.ecrc_fail || evt.poison_rx;
	wire mdpe_set = evt.poison_rx && evt.poison_is_read_cpl && cfg.parity_error_response_enable;

	// The target's parity pin is sampled in the cycle the poisoned write
	// is flagged as forwarded.
	wire target_perr = !secondary_parity_error_pin_b;
	wire sec_mdpe_set = evt.poison_write_fwd && cfg.secondary_parity_response_enable && target_perr;

	// ********************************
	// Status set vector
	// ********************************
	bte_stat_t stat_set;

	always_comb begin
		stat_set = '0;
		stat_set.completion_timeout_status = cto_evt;
		stat_set.discard_timer_timeout_status = evt.discard_timeout;
		stat_set.signaled_system_error = sse_set;
		stat_set.sec_received_system_error = evt.sec_serr_seen;
		stat_set.secondary_serr_asserted_status = evt.sec_serr_seen;
		stat_set.detected_parity_error = dpe_set;
		stat_set.fatal_error_detected = fatal_det;
		stat_set.nonfatal_error_detected = nonfatal_det;
		stat_set.correctable_error_detected = poison_adv;
		stat_set.advisory_nonfatal_status = poison_adv;
		stat_set.poisoned_packet_status = evt.poison_rx;
		stat_set.ecrc_status = evt.ecrc_fail;
		stat_set.master_data_parity_error = mdpe_set;
		stat_set.secondary_parity_asserted_status = evt.poison_write_fwd;
		stat_set.sec_master_data_parity_error = sec_mdpe_set;
	end

	// A set in the same cycle as its clear survives, so no event is lost.
	wire bte_stat_t stat_next = (status_reg & ~status_clear) | stat_set;

	// ********************************
	// First-error pointer
	// ********************************
	// Only the pointer moves; no header is captured for this source, and
	// there is no header capture path in this block at all.
	logic [`BTE_PTR_W-1:0] ptr_next;

	always_comb begin
		ptr_next = secondary_first_error_pointer_reg;
		if (first_error_pointer_clear) begin
			ptr_next = `BTE_PTR_RST;
		end
		if (evt.sec_serr_seen) begin
			ptr_next = `BTE_PTR_SEC_SERR;
		end
	end

	// ********************************
	// Status and pointer registers
	// ********************************
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			status_reg <= '0;
			secondary_first_error_pointer_reg <= `BTE_PTR_RST;
		end else begin
			status_reg <= stat_next;
			secondary_first_error_pointer_reg <= ptr_next;
		end
	end

	// ********************************
	// Upstream message requests
	// ********************************
	// Fatal and non-fatal requests may pulse together when sources of both
	// severities fire at once; the message sender queues both.
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			err_msg_reg <= '0;
		end else begin
			err_msg_reg.fatal <= fatal_send;
			err_msg_reg.nonfatal <= nonfatal_send;
		end
	end

	// ********************************
	// Request abort and packet drop
	// ********************************
	// The transaction layer finishes a timed-out request exactly as it
	// would a received Unsupported Request completion.
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			ur_abort_reg <= 1'b0;
			ur_abort_tag_reg <= '0;
		end else begin
			ur_abort_reg <= cto_evt;
			ur_abort_tag_reg <= cto_tag;
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			tlp_discard_reg <= 1'b0;
		end else begin
			tlp_discard_reg <= evt.ecrc_fail;
		end
	end

	// ********************************
	// Tag occupancy
	// ********************************
	// A request issued on a busy tag is ignored, so the issuer should
	// check this before using a tag.
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			tag_busy_reg <= '0;
		end else begin
			tag_busy_reg <= busy;
		end
	end

endmodule

// *** bte_report_chk.sv ***
/* Port checker for the error-reporting core.
   Assumes cfg is held steady around the events that it qualifies. */
`timescale 1ns/10ps
`include "bte_err_map.svh"
module bte_report_chk #(
	parameter int unsigned CTO_CYCLES = `BTE_CTO_CYCLES
) (
	input wire logic core_clk,
	input wire logic rst_b,
	input bte_pkg::bte_cfg_t cfg,
	input bte_pkg::bte_evt_t evt,
	input wire logic np_issue,
	input wire logic [`BTE_TAG_W-1:0] np_issue_tag,
	input wire logic cpl_rcvd,
	input wire logic [`BTE_TAG_W-1:0] cpl_rcvd_tag,
	input wire logic secondary_parity_error_pin_b,
	input bte_pkg::bte_stat_t status_clear,
	input wire logic first_error_pointer_clear,
	input bte_pkg::bte_stat_t status_reg,
	input wire logic [`BTE_PTR_W-1:0] secondary_first_error_pointer_reg,
	input bte_pkg::bte_msg_t err_msg_reg,
	input wire logic ur_abort_reg,
	input wire logic [`BTE_TAG_W-1:0] ur_abort_tag_reg,
	input wire logic tlp_discard_reg,
	input wire logic [`BTE_TAGS-1:0] tag_busy_reg
);
	import bte_pkg::*;
	// *****
	// Tag 0 age, so a stuck or early timer shows.
	// *****
	logic [15:0] busy_cnt_reg;
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			busy_cnt_reg <= 16'h0000;
		end else begin
			busy_cnt_reg <= tag_busy_reg[0] ? busy_cnt_reg + 16'h0001 : 16'h0000;
		end
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_b);
	sequence s_abort0;
		ur_abort_reg && ur_abort_tag_reg == 2'h0;
	endsequence
	sequence s_sec_serr;
		evt.sec_serr_seen && !first_error_pointer_clear;
	endsequence
	a_abort_window: assert property (s_abort0 |-> busy_cnt_reg inside {[CTO_CYCLES-2:CTO_CYCLES+2]})
		else $error("timeout abort out of window");
	a_busy_bound: assert property (busy_cnt_reg <= CTO_CYCLES + 4)
		else $error("tag held past timeout");
	a_abort_status: assert property (ur_abort_reg |-> status_reg.completion_timeout_status)
		else $error("abort without timeout status");
	a_cto_msg: assert property (ur_abort_reg && !$past(cfg.cto_mask) && $past(cfg.system_error_enable) |-> |err_msg_reg)
		else $error("timeout message missing");
	a_msg_cause: assert property (|err_msg_reg |-> ur_abort_reg || $past(|evt[6:3]))
		else $error("message without cause");
	a_msg_sserr: assert property (|err_msg_reg && $past(cfg.system_error_enable) && !$past(evt.poison_rx)
		|-> status_reg.signaled_system_error)
		else $error("signaled error missing");
	a_ecrc_bits: assert property (evt.ecrc_fail |=> status_reg.ecrc_status && status_reg.detected_parity_error
		&& tlp_discard_reg)
		else $error("ecrc bits missing");
	a_poison_bits: assert property (evt.poison_rx |=> status_reg.poisoned_packet_status
		&& status_reg.detected_parity_error)
		else $error("poison bits missing");
	a_advisory_bits: assert property (evt.poison_rx && evt.poison_advisory |=> status_reg.advisory_nonfatal_status
		&& !(|err_msg_reg))
		else $error("advisory handling wrong");
	a_rdcpl_parity: assert property (evt.poison_rx && evt.poison_is_read_cpl && cfg.parity_error_response_enable
		|=> status_reg.master_data_parity_error)
		else $error("read parity bit missing");
	a_wfwd_parity: assert property (evt.poison_write_fwd |=> status_reg.secondary_parity_asserted_status
		&& status_reg.sec_master_data_parity_error == $past(cfg.secondary_parity_response_enable
		&& !secondary_parity_error_pin_b))
		else $error("forwarded write parity wrong");
	a_serr_ptr: assert property (s_sec_serr |=> status_reg.sec_received_system_error
		&& status_reg.secondary_serr_asserted_status && secondary_first_error_pointer_reg == `BTE_PTR_SEC_SERR)
		else $error("secondary error state wrong");
endmodule

// *** bte_report_tb_top.sv ***
/* Bench for the error-reporting core.
   Assumes the far-side model and checker are compiled alongside. */
`timescale 1ns/10ps
`include "bte_err_map.svh"
module bte_report_tb_top;
	import bte_pkg::*;
	localparam int CTO = 20;
	logic core_clk = 1'b0;
	logic rst_b = 1'b0;
	bte_cfg_t cfg = '0;
	bte_evt_t evt = '0;
	logic np_issue = 1'b0;
	logic [`BTE_TAG_W-1:0] np_issue_tag = '0;
	logic cpl_rcvd;
	logic [`BTE_TAG_W-1:0] cpl_rcvd_tag;
	logic secondary_parity_error_pin_b;
	bte_stat_t status_clear = '0;
	logic first_error_pointer_clear = 1'b0;
	bte_stat_t status_reg;
	logic [`BTE_PTR_W-1:0] secondary_first_error_pointer_reg;
	bte_msg_t err_msg_reg;
	logic ur_abort_reg;
	logic [`BTE_TAG_W-1:0] ur_abort_tag_reg;
	logic tlp_discard_reg;
	logic [`BTE_TAGS-1:0] tag_busy_reg;
	logic lose_cpl = 1'b0;
	logic flag_parity = 1'b0;
	int miscompares = 0;
	int num_checks = 0;
	always #4 core_clk = ~core_clk;
	bte_report #(.CTO_CYCLES(CTO)) i_bte_report (.core_clk, .rst_b, .cfg, .evt, .np_issue, .np_issue_tag,
		.cpl_rcvd, .cpl_rcvd_tag, .secondary_parity_error_pin_b, .status_clear, .first_error_pointer_clear,
		.status_reg, .secondary_first_error_pointer_reg, .err_msg_reg, .ur_abort_reg, .ur_abort_tag_reg,
		.tlp_discard_reg, .tag_busy_reg);
	bte_far_end i_bte_far_end (.core_clk, .rst_b, .lose_cpl, .flag_parity, .poison_write_fwd(evt.poison_write_fwd),
		.np_issue, .np_issue_tag, .cpl_rcvd, .cpl_rcvd_tag, .secondary_parity_error_pin_b);
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] %0t got %0h exp %0h", $time, got, exp);
		end
	endtask
	function automatic logic [1:0] msg(input logic on, input logic sev);
		return on ? {sev, !sev} : 2'h0;
	endfunction
	// Clears in its own cycle, because set wins over clear.
	task automatic fire(input bte_evt_t e);
		@(posedge core_clk);
		status_clear <= '1;
		first_error_pointer_clear <= 1'b1;
		@(posedge core_clk);
		status_clear <= '0;
		first_error_pointer_clear <= 1'b0;
		evt <= e;
		@(posedge core_clk);
		evt <= '0;
		#1;
	endtask
	task automatic t_ecrc();
		for (int i = 0; i < 8; i++) begin
			cfg <= '{system_error_enable: i[2], fatal_report_enable: 1'b1, ecrc_mask: i[1], ecrc_severity: i[0],
				default: 1'b0};
			fire('{ecrc_fail: 1'b1, default: 1'b0});
			chk({status_reg.ecrc_status, status_reg.detected_parity_error, tlp_discard_reg}, 3'h7);
			chk({status_reg.fatal_error_detected, status_reg.nonfatal_error_detected}, {i[0], !i[0]});
			chk(err_msg_reg, msg(!i[1] && (i[2] || i[0]), i[0]));
			chk(status_reg.signaled_system_error, !i[1] && i[2]);
		end
	endtask
	task automatic t_discard();
		for (int i = 0; i < 8; i++) begin
			cfg <= '{system_error_enable: 1'b1, dtd_mask: i[0], discard_timeout_serr_enable: i[1], dtd_severity: i[2],
				default: 1'b0};
			fire('{discard_timeout: 1'b1, default: 1'b0});
			chk(err_msg_reg, msg(!i[0] || i[1], i[2]));
			chk({status_reg.discard_timer_timeout_status, status_reg.signaled_system_error}, {1'b1, !i[0] || i[1]});
			chk(secondary_first_error_pointer_reg, `BTE_PTR_RST);
		end
	endtask
	task automatic t_serr();
		for (int i = 0; i < 8; i++) begin
			cfg <= '{nonfatal_report_enable: 1'b1, sec_serr_mask: i[0], bridge_serr_forward_enable: i[1],
				sec_serr_severity: i[2], default: 1'b0};
			fire('{sec_serr_seen: 1'b1, default: 1'b0});
			chk(status_reg.sec_received_system_error, 1'b1);
			chk(err_msg_reg, msg((!i[0] || i[1]) && !i[2], 1'b0));
			chk(status_reg.secondary_serr_asserted_status, 1'b1);
			chk(secondary_first_error_pointer_reg, `BTE_PTR_SEC_SERR);
			chk(status_reg.signaled_system_error, 1'b0);
		end
	endtask
	task automatic t_poison();
		for (int i = 0; i < 2; i++) begin
			cfg <= '{system_error_enable: 1'b1, parity_error_response_enable: 1'b1, poison_severity: i[0],
				default: 1'b0};
			fire('{poison_rx: 1'b1, poison_is_read_cpl: i[0], default: 1'b0});
			chk({status_reg.poisoned_packet_status, status_reg.detected_parity_error}, 2'h3);
			chk(err_msg_reg, msg(1'b1, i[0]));
			chk(status_reg.signaled_system_error, i[0]);
			chk(status_reg.master_data_parity_error, i[0]);
		end
		fire('{poison_rx: 1'b1, poison_advisory: 1'b1, default: 1'b0});
		chk({status_reg.advisory_nonfatal_status, status_reg.correctable_error_detected}, 2'h3);
		chk({err_msg_reg, status_reg.fatal_error_detected}, 3'h0);
		for (int i = 0; i < 2; i++) begin
			cfg <= '{secondary_parity_response_enable: 1'b1, default: 1'b0};
			flag_parity <= i[0];
			fire('{poison_write_fwd: 1'b1, default: 1'b0});
			chk(status_reg.secondary_parity_asserted_status, 1'b1);
			chk(status_reg.sec_master_data_parity_error, i[0]);
		end
	endtask
	task automatic t_cto();
		int n;
		cfg <= '{system_error_enable: 1'b1, cto_severity: 1'b1, default: 1'b0};
		lose_cpl <= 1'b1;
		fire('0);
		@(posedge core_clk);
		np_issue <= 1'b1;
		np_issue_tag <= 2'h0;
		@(posedge core_clk);
		np_issue <= 1'b0;
		n = 0;
		// A second issue on the busy tag must not restart its timer.
		while (ur_abort_reg !== 1'b1 && n < 100) begin
			@(posedge core_clk);
			np_issue <= (n == 4);
			#1;
			n++;
		end
		chk(n, CTO + 1);
		chk({ur_abort_tag_reg, status_reg.completion_timeout_status}, 3'h1);
		chk(err_msg_reg, 2'h2);
		chk(status_reg.signaled_system_error, 1'b1);
		@(posedge core_clk);
		lose_cpl <= 1'b0;
		np_issue <= 1'b1;
		np_issue_tag <= 2'h1;
		@(posedge core_clk);
		np_issue <= 1'b0;
		n = 0;
		repeat (2 * CTO) begin
			@(posedge core_clk);
			#1;
			if (ur_abort_reg === 1'b1) begin
				n++;
			end
		end
		chk(n, 0);
		chk(tag_busy_reg, 4'h0);
	endtask
	task automatic results();
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	initial begin
		repeat (6) @(posedge core_clk);
		rst_b <= 1'b1;
		@(posedge core_clk);
		#1;
		chk(status_reg, '0);
		t_ecrc();
		t_discard();
		t_serr();
		t_poison();
		t_cto();
		results();
	end
	initial begin
		#100000;
		miscompares++;
		results();
	end
endmodule
bind bte_report bte_report_chk #(.CTO_CYCLES(CTO_CYCLES)) i_bte_report_chk (.core_clk, .rst_b, .cfg, .evt,
	.np_issue, .np_issue_tag, .cpl_rcvd, .cpl_rcvd_tag, .secondary_parity_error_pin_b, .status_clear,
	.first_error_pointer_clear, .status_reg, .secondary_first_error_pointer_reg, .err_msg_reg, .ur_abort_reg,
	.ur_abort_tag_reg, .tlp_discard_reg, .tag_busy_reg);
